// [agu_pkg.sv]
// Constants and types shared by the address generator units
// ****************************************
// Overview of operation
// - Two independent generators; Y serves only word reads of multiply-accumulate class.
// - Linear and circular addressing serve data and program space addresses.
// - File-register mode uses a 13-bit direct address; working register zero is default operand.
// - First operand is a direct register; second is register, memory or 5-bit literal.
// - Plain indirect uses pointer as address; post-modify updates pointer after use.
// - Pre-modify adds a signed constant first, then uses the updated pointer.
// - Indexed mode adds offset register; literal-offset mode adds instruction literal.
// - Move and accumulator class add indexed mode plus 8-bit and 16-bit literals.
// - Move source and destination share one 4-bit offset-register field.
// - Multiply-accumulate pointers are registers 8-11; 8,9 go to X, 10,11 to Y.
// - Multiply-accumulate modes: indirect, post-modify by 2/4/6, indexed only on 9 and 11.
// - Branch carries 16-bit signed literal; interrupt-disable carries 14-bit unsigned literal.
// - One circular buffer in X and one in Y; X also covers program space.
// - Non power-of-two buffers wrap one way; power-of-two buffers check both bounds.
// - Each space has a 16-bit start and 16-bit end bound register.
// - Y circular addresses are word addresses; bit zero is held clear.
// - Length follows from start and end bounds; longest buffer is 32K words.
// - X circular active only when X select is not 15 and bit 15 enables.
// - Y circular active only when Y select is not 15 and bit 14 enables.
// - Bound checks catch overshoot; corrected value written back only for pre/post modify.
// ****************************************
package agu_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [9:0] CTRL_IDX = 10'h046;
  localparam logic [9:0] X_START_IDX = 10'h048;
  localparam logic [9:0] X_END_IDX = 10'h04a;
  localparam logic [9:0] Y_START_IDX = 10'h04c;
  localparam logic [9:0] Y_END_IDX = 10'h04e;
  localparam logic [9:0] X_LAST_IDX = 10'h060;
  localparam logic [9:0] Y_LAST_IDX = 10'h062;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CTRL_MASK = 16'hc0ff;
  localparam logic [15:0] START_RST = 16'h0000;
  localparam logic [15:0] END_RST = 16'h0001;
  localparam int unsigned X_EN_BIT = 15;
  localparam int unsigned Y_EN_BIT = 14;
  localparam int unsigned X_SEL_LSB = 0;
  localparam int unsigned Y_SEL_LSB = 4;
  localparam logic [3:0] SEL_OFF = 4'hf;
  localparam logic [3:0] MAC_X_IDX = 4'h9;
  localparam logic [3:0] MAC_Y_IDX = 4'hb;
  localparam logic [1:0] MAC_GROUP = 2'b10;
  localparam logic [3:0] WREG0 = 4'h0;
  localparam int unsigned FA_W = 13;

  typedef enum logic [3:0] {
    M_FILE = 4'b0000,
    M_DIRECT = 4'b0001,
    M_IND = 4'b0010,
    M_POST = 4'b0011,
    M_PRE = 4'b0100,
    M_REG_OFF = 4'b0101,
    M_LIT_OFF = 4'b0110,
    M_LIT = 4'b0111,
    M_MAC_IND = 4'b1000,
    M_MAC_POST = 4'b1001,
    M_MAC_IDX = 4'b1010
  } mode_t;

  typedef enum logic [2:0] {
    L_5 = 3'b000,
    L_8 = 3'b001,
    L_14 = 3'b010,
    L_16 = 3'b011,
    L_BRANCH = 3'b100
  } lit_kind_t;

  typedef struct packed {
    logic valid;
    mode_t mode;
    logic prog;
    logic [3:0] ptr;
    logic [3:0] off;
    logic [15:0] lit;
    lit_kind_t lkind;
    logic [FA_W-1:0] fa;
  } agu_req_t;

  typedef struct packed {
    logic valid;
    logic y_space;
    logic prog;
    logic illegal;
    logic circ;
    logic [15:0] ea;
    logic [15:0] operand;
  } agu_rsp_t;
endpackage : agu_pkg

// [agu_top.sv]
// Dual X/Y effective-address generator with circular buffers and register slave
`timescale 1ns/1ps
`default_nettype none
module agu_top (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [agu_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire agu_pkg::agu_req_t req,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [15:0] wr_data,
  output agu_pkg::agu_rsp_t rsp
);
  import agu_pkg::*;

  function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  function automatic logic [15:0] lit_ext(input lit_kind_t k, input logic [15:0] l);
    unique case (k)
      L_5: lit_ext = {11'h000, l[4:0]};
      L_8: lit_ext = {8'h00, l[7:0]};
      L_14: lit_ext = {2'b00, l[13:0]};
      L_16: lit_ext = l;
      L_BRANCH: lit_ext = l;
      default: lit_ext = l;
    endcase
  endfunction : lit_ext

  // ****************************************
  // Register slave
  // ****************************************
  logic [15:0] ctrl_q, ctrl_d, xs_q, xs_d, xe_q, xe_d, ys_q, ys_d, ye_q, ye_d;
  logic [15:0] xlast_q, ylast_q;
  logic [31:0] rdata_q, rdata_d;
  logic wait_q, wait_d;
  logic [9:0] idx;
  logic [15:0] rsel;
  logic [15:0] wd16;
  logic wr_take;

  always_comb begin
    idx = avs_address[ADDR_W-1:2];
    wd16 = avs_writedata[15:0];
    // One wait cycle: request seen, then answer on the next edge
    wr_take = avs_write && !wait_q;
    ctrl_d = ctrl_q;
    xs_d = xs_q;
    xe_d = xe_q;
    ys_d = ys_q;
    ye_d = ye_q;
    rdata_d = rdata_q;
    wait_d = 1'b1;
    unique case (idx)
      CTRL_IDX: rsel = ctrl_q;
      X_START_IDX: rsel = xs_q;
      X_END_IDX: rsel = xe_q;
      Y_START_IDX: rsel = ys_q;
      Y_END_IDX: rsel = ye_q;
      X_LAST_IDX: rsel = xlast_q;
      Y_LAST_IDX: rsel = ylast_q;
      default: rsel = 16'h0000;
    endcase
    if ((avs_read || avs_write) && wait_q) begin
      wait_d = 1'b0;
      rdata_d = {16'h0000, rsel};
    end
    if (wr_take) begin
      unique case (idx)
        CTRL_IDX: ctrl_d = be_merge(ctrl_q, wd16, avs_byteenable[1:0]) & CTRL_MASK;
        // Start stays even, end stays odd: buffers hold whole words
        X_START_IDX: xs_d = be_merge(xs_q, wd16, avs_byteenable[1:0]) & 16'hfffe;
        X_END_IDX: xe_d = be_merge(xe_q, wd16, avs_byteenable[1:0]) | 16'h0001;
        Y_START_IDX: ys_d = be_merge(ys_q, wd16, avs_byteenable[1:0]) & 16'hfffe;
        Y_END_IDX: ye_d = be_merge(ye_q, wd16, avs_byteenable[1:0]) | 16'h0001;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= CTRL_RST;
      xs_q <= START_RST;
      xe_q <= END_RST;
      ys_q <= START_RST;
      ye_q <= END_RST;
      rdata_q <= 32'h0000_0000;
      wait_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      xs_q <= xs_d;
      xe_q <= xe_d;
      ys_q <= ys_d;
      ye_q <= ye_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;

  // ****************************************
  // Address computation
  // ****************************************
  logic [15:0] w_q [16];
  logic [15:0] w_d [16];
  logic [15:0] base, offv, delta, x_sum, y_sum, sum;
  logic x_act, y_act, x_wrap, y_wrap;
  logic is_mac, ysp, illegal, wb_en;
  logic [3:0] x_sel, y_sel;
  agu_rsp_t rsp_q, rsp_d;

  always_comb begin
    x_sel = ctrl_q[X_SEL_LSB +: 4];
    y_sel = ctrl_q[Y_SEL_LSB +: 4];
    base = w_q[req.ptr];
    offv = w_q[req.off]; // Shared offset field for both move ends
    is_mac = req.mode[3];
    ysp = is_mac && req.ptr[1];
    illegal = is_mac && (req.ptr[3:2] != MAC_GROUP);
    delta = 16'h0000;
    unique case (req.mode)
      M_POST, M_PRE, M_LIT_OFF: delta = req.lit;
      M_REG_OFF: delta = offv;
      M_MAC_POST: begin
        delta = {13'h0000, req.lit[1:0], 1'b0};
        illegal = illegal || (req.lit[1:0] == 2'b00);
      end
      M_MAC_IDX: begin
        delta = offv;
        illegal = illegal || ((req.ptr != MAC_X_IDX) && (req.ptr != MAC_Y_IDX));
      end
      default: delta = 16'h0000;
    endcase
    // X bounds also steer program space pointers
    x_act = ctrl_q[X_EN_BIT] && (x_sel != SEL_OFF) && (x_sel == req.ptr) && !ysp;
    y_act = ctrl_q[Y_EN_BIT] && (y_sel != SEL_OFF) && (y_sel == req.ptr) && ysp;
  end

  circ_wrap u_x_gen (
    .base(base),
    .delta(delta),
    .active(x_act),
    .word_only(1'b0),
    .start_bound(xs_q),
    .end_bound(xe_q),
    .sum(x_sum),
    .wrapped(x_wrap)
  );

  circ_wrap u_y_gen (
    .base(base),
    .delta(delta),
    .active(y_act),
    .word_only(1'b1),
    .start_bound(ys_q),
    .end_bound(ye_q),
    .sum(y_sum),
    .wrapped(y_wrap)
  );

  always_comb begin
    sum = ysp ? y_sum : x_sum;
    wb_en = 1'b0;
    rsp_d = '0;
    rsp_d.valid = req.valid;
    rsp_d.y_space = ysp;
    rsp_d.prog = req.prog && !ysp;
    rsp_d.illegal = illegal;
    rsp_d.circ = x_wrap || y_wrap;
    unique case (req.mode)
      M_FILE: begin
        rsp_d.ea = {{(16 - FA_W){1'b0}}, req.fa};
        rsp_d.operand = w_q[WREG0];
      end
      M_DIRECT: rsp_d.operand = base;
      M_LIT: rsp_d.operand = lit_ext(req.lkind, req.lit);
      M_POST, M_MAC_POST: begin
        rsp_d.ea = ysp ? {base[15:1], 1'b0} : base;
        wb_en = 1'b1;
      end
      M_PRE: begin
        rsp_d.ea = sum;
        wb_en = 1'b1;
      end
      // Offset forms get the corrected address but leave the pointer alone
      default: rsp_d.ea = sum;
    endcase
    if (illegal) begin
      rsp_d.ea = 16'h0000;
      wb_en = 1'b0;
    end
    for (int i = 0; i < 16; i++) begin
      w_d[i] = w_q[i];
    end
    if (wr_en) begin
      w_d[wr_idx] = wr_data;
    end
    // Pointer update outranks a pipeline load to the same register
    if (req.valid && wb_en) begin
      w_d[req.ptr] = sum;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 16; i++) begin
        w_q[i] <= 16'h0000;
      end
      rsp_q <= '0;
      xlast_q <= 16'h0000;
      ylast_q <= 16'h0000;
    end else begin
      for (int i = 0; i < 16; i++) begin
        w_q[i] <= w_d[i];
      end
      rsp_q <= rsp_d;
      xlast_q <= (req.valid && !ysp) ? rsp_d.ea : xlast_q;
      ylast_q <= (req.valid && ysp) ? rsp_d.ea : ylast_q;
    end
  end

  assign rsp = rsp_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_file_reg_ea: assert property (req.valid && req.mode == M_FILE |=>
    rsp.ea == {3'b000, $past(req.fa)} && rsp.operand == $past(w_q[0]))
    else $error("file register address or default operand wrong");
  chk_y_word_ea: assert property (rsp.valid && rsp.y_space |-> !rsp.ea[0])
    else $error("Y address has bit zero set");
  chk_mac_space_map: assert property (req.valid && is_mac && req.ptr[3:2] == MAC_GROUP |=>
    rsp.y_space == $past(req.ptr[1]) && ($past(req.mode) != M_MAC_IND || !rsp.illegal))
    else $error("multiply-accumulate pointer sent to wrong space");
  chk_mac_idx_only: assert property (req.valid && req.mode == M_MAC_IDX && req.ptr == 4'h8 |=>
    rsp.illegal && rsp.ea == 16'h0000)
    else $error("indexed multiply-accumulate accepted on register 8");
  chk_x_circ_gate: assert property (!ctrl_q[X_EN_BIT] || x_sel == SEL_OFF |-> !x_act)
    else $error("X circular active while disabled");
  chk_y_circ_gate: assert property (!ctrl_q[Y_EN_BIT] || y_sel == SEL_OFF |-> !y_act)
    else $error("Y circular active while disabled");
  chk_post_ea_base: assert property (req.valid && req.mode == M_POST && !wr_en |=>
    rsp.ea == $past(base) && w_q[$past(req.ptr)] == $past(x_sum))
    else $error("post-modify address or update wrong");
  chk_pre_ea_update: assert property (req.valid && req.mode == M_PRE && !wr_en |=>
    rsp.ea == w_q[$past(req.ptr)])
    else $error("pre-modify address differs from updated pointer");
  chk_idx_no_wb: assert property (req.valid && req.mode == M_REG_OFF && !wr_en |=>
    w_q[$past(req.ptr)] == $past(base))
    else $error("indexed mode changed its pointer");
  chk_ctrl_write: assert property (wr_take && idx == CTRL_IDX && avs_byteenable[1] |=>
    ctrl_q[X_EN_BIT] == $past(avs_writedata[X_EN_BIT]))
    else $error("control write not taken");
  chk_bus_answer: assert property ((avs_read || avs_write) && wait_q |=> !wait_q ##1 wait_q)
    else $error("bus answer not one cycle later");

  cov_x_wrap_pre: cover property (req.valid && req.mode == M_PRE && x_wrap);
  cov_y_wrap_mac: cover property (req.valid && req.mode == M_MAC_POST && y_wrap);
  cov_bus_read: cover property (avs_read && !wait_q);
endmodule : agu_top
`default_nettype wire

// [circ_wrap.sv]
// One circular-buffer address adder with bound correction
`timescale 1ns/1ps
`default_nettype none
module circ_wrap (
  input wire logic [15:0] base,
  input wire logic [15:0] delta,
  input wire logic active,
  input wire logic word_only,
  input wire logic [15:0] start_bound,
  input wire logic [15:0] end_bound,
  output logic [15:0] sum,
  output logic wrapped
);
  logic [15:0] raw;
  logic [16:0] len;
  logic pow2;
  logic up;
  logic [15:0] fixed;

  // ****************************************
  // Wrap logic
  // ****************************************
  always_comb begin
    raw = base + delta;
    len = {1'b0, end_bound} - {1'b0, start_bound} + 17'h0_0001;
    pow2 = ((len & (len - 17'h0_0001)) == 17'h0_0000);
    up = !delta[15];
    fixed = raw;
    wrapped = 1'b0;
    // Compare beyond, not equal, so jumps up to one buffer length past a bound still land inside
    if (active && (up || pow2) && (raw > end_bound)) begin
      fixed = raw - len[15:0];
      wrapped = 1'b1;
    end else if (active && (!up || pow2) && (raw < start_bound)) begin
      fixed = raw + len[15:0];
      wrapped = 1'b1;
    end
    sum = word_only ? {fixed[15:1], 1'b0} : fixed;
  end
endmodule : circ_wrap
`default_nettype wire

// [dsp_address_generator_units_tb.sv]
// Self-checking bench for the dual address generator block
`timescale 1ns/1ps
`default_nettype none
module dsp_address_generator_units_tb;
  import agu_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  agu_req_t req;
  logic wr_en;
  logic [3:0] wr_idx;
  logic [15:0] wr_data;
  agu_rsp_t rsp;
  agu_rsp_t r;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 clk_sys = ~clk_sys;
  agu_top i_dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .req(req), .wr_en(wr_en),
    .wr_idx(wr_idx), .wr_data(wr_data), .rsp(rsp));
  pipe_model i_cpu (.clk_sys(clk_sys), .req(req), .wr_en(wr_en), .wr_idx(wr_idx), .wr_data(wr_data), .rsp(rsp));
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // Request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [15:0] wdat, output logic [31:0] rdat);
    @(posedge clk_sys);
    avs_address <= {idx, 2'b00};
    avs_read <= ~wr;
    avs_write <= wr;
    avs_writedata <= {16'hffff, wdat};
    avs_byteenable <= 4'h3;
    // Settled value; the next rising edge takes it low
    @(negedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(negedge clk_sys);
    rdat = avs_readdata;
    @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic wr(input logic [9:0] idx, input logic [15:0] val);
    logic [31:0] d;
    bus(1'b1, idx, val, d);
  endtask : wr
  task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, idx, 16'h0000, d);
    check(d, exp);
  endtask : rd
  task automatic op(input mode_t m, input logic [3:0] p, input logic [3:0] o, input logic [15:0] l,
                    input logic ill, input logic [15:0] ea);
    i_cpu.issue(m, p, o, l, L_16, 13'h0000, 1'b0, r);
    check(32'({r.valid, r.illegal, r.ea}), 32'({1'b1, ill, ea}));
  endtask : op
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    rd(CTRL_IDX, 32'h0000_0000);
    rd(X_START_IDX, 32'h0000_0000);
    rd(X_END_IDX, 32'h0000_0001);
    rd(Y_START_IDX, 32'h0000_0000);
    rd(Y_END_IDX, 32'h0000_0001);
    wr(CTRL_IDX, 16'hffff);
    rd(CTRL_IDX, 32'h0000_c0ff);
    wr(X_START_IDX, 16'h1235);
    rd(X_START_IDX, 32'h0000_1234);
    wr(Y_END_IDX, 16'h1234);
    rd(Y_END_IDX, 32'h0000_1235);
    wr(10'h050, 16'h1234);
    rd(10'h050, 32'h0000_0000);
    wr(CTRL_IDX, 16'h0000);
  endtask : t_regs
  task automatic t_file_lit();
    logic [15:0] lmask [5] = '{16'h001f, 16'h00ff, 16'h3fff, 16'hffff, 16'hffff};
    i_cpu.load(WREG0, 16'h5a5a);
    i_cpu.issue(M_FILE, 4'h3, 4'h0, 16'h0000, L_16, 13'h1abc, 1'b0, r);
    check(32'({r.ea, r.operand}), 32'h1abc_5a5a);
    for (int i = 0; i < 5; i++) begin
      i_cpu.issue(M_LIT, 4'h0, 4'h0, 16'hffff, lit_kind_t'(3'(i)), 13'h0000, 1'b0, r);
      check(32'(r.operand), 32'(lmask[i]));
    end
  endtask : t_file_lit
  task automatic t_indirect();
    i_cpu.load(4'h1, 16'h1000);
    i_cpu.load(4'h2, 16'h0010);
    i_cpu.issue(M_DIRECT, 4'h2, 4'h0, 16'h0000, L_16, 13'h0000, 1'b0, r);
    check(32'(r.operand), 32'h0000_0010);
    op(M_IND, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h1000);
    op(M_POST, 4'h1, 4'h0, 16'h0002, 1'b0, 16'h1000);
    op(M_PRE, 4'h1, 4'h0, 16'hfffc, 1'b0, 16'h0ffe);
    op(M_REG_OFF, 4'h1, 4'h2, 16'h0000, 1'b0, 16'h100e);
    op(M_LIT_OFF, 4'h1, 4'h0, 16'h0004, 1'b0, 16'h1002);
    op(M_IND, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h0ffe);
    rd(X_LAST_IDX, 32'h0000_0ffe);
  endtask : t_indirect
  task automatic t_mac();
    logic [15:0] ea;
    i_cpu.load(4'h8, 16'h0800);
    i_cpu.load(4'h9, 16'h0900);
    i_cpu.load(4'hb, 16'h1801);
    i_cpu.load(4'h3, 16'h0020);
    op(M_MAC_IND, 4'h8, 4'h0, 16'h0000, 1'b0, 16'h0800);
    check(32'(r.y_space), 32'h0000_0000);
    op(M_MAC_IND, 4'hb, 4'h0, 16'h0000, 1'b0, 16'h1800);
    check(32'(r.y_space), 32'h0000_0001);
    ea = 16'h0900;
    for (int k = 1; k < 4; k++) begin
      op(M_MAC_POST, 4'h9, 4'h0, 16'(k), 1'b0, ea);
      ea = ea + 16'(2 * k);
    end
    op(M_MAC_IDX, 4'h9, 4'h3, 16'h0000, 1'b0, 16'h092c);
    op(M_MAC_IDX, 4'h8, 4'h3, 16'h0000, 1'b1, 16'h0000);
    op(M_MAC_IND, 4'h5, 4'h0, 16'h0000, 1'b1, 16'h0000);
    op(M_MAC_POST, 4'h9, 4'h0, 16'h0000, 1'b1, 16'h0000);
    op(M_MAC_IND, 4'h9, 4'h0, 16'h0000, 1'b0, 16'h090c);
  endtask : t_mac
  task automatic t_circ_x();
    wr(X_START_IDX, 16'h1000);
    wr(X_END_IDX, 16'h100f);
    wr(CTRL_IDX, 16'h8001);
    i_cpu.load(4'h1, 16'h100c);
    i_cpu.load(4'h2, 16'h0014);
    op(M_POST, 4'h1, 4'h0, 16'h0004, 1'b0, 16'h100c);
    op(M_IND, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h1000);
    i_cpu.issue(M_LIT_OFF, 4'h1, 4'h0, 16'h0012, L_16, 13'h0000, 1'b1, r);
    check(32'({r.prog, r.circ, r.ea}), 32'h0003_1002);
    op(M_PRE, 4'h1, 4'h0, 16'hfffa, 1'b0, 16'h100a);
    op(M_REG_OFF, 4'h1, 4'h2, 16'h0000, 1'b0, 16'h100e);
    op(M_IND, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h100a);
    check(32'(r.circ), 32'h0000_0000);
    wr(CTRL_IDX, 16'h800f);
    op(M_POST, 4'h1, 4'h0, 16'h0008, 1'b0, 16'h100a);
    wr(CTRL_IDX, 16'h0001);
    op(M_POST, 4'h1, 4'h0, 16'h0002, 1'b0, 16'h1012);
    op(M_IND, 4'h1, 4'h0, 16'h0000, 1'b0, 16'h1014);
  endtask : t_circ_x
  task automatic t_circ_y();
    wr(Y_START_IDX, 16'h2000);
    wr(Y_END_IDX, 16'h2007);
    wr(CTRL_IDX, 16'h40a0);
    i_cpu.load(4'ha, 16'h2006);
    op(M_MAC_POST, 4'ha, 4'h0, 16'h0001, 1'b0, 16'h2006);
    op(M_MAC_IND, 4'ha, 4'h0, 16'h0000, 1'b0, 16'h2000);
    rd(Y_LAST_IDX, 32'h0000_2000);
    wr(CTRL_IDX, 16'h40f0);
    op(M_MAC_POST, 4'ha, 4'h0, 16'h0003, 1'b0, 16'h2000);
    op(M_MAC_IND, 4'ha, 4'h0, 16'h0000, 1'b0, 16'h2006);
  endtask : t_circ_y
  initial begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_file_lit();
    t_indirect();
    t_mac();
    t_circ_x();
    t_circ_y();
    results();
  end
  // Whole sequence needs about 200 cycles
  initial begin
    repeat (6000) @(posedge clk_sys);
    bad_count++;
    results();
  end
endmodule : dsp_address_generator_units_tb
`default_nettype wire

// [pipe_model.sv]
// Pipeline model issuing address requests and working register loads
`timescale 1ns/1ps
`default_nettype none
module pipe_model (
  input wire logic clk_sys,
  output agu_pkg::agu_req_t req,
  output logic wr_en,
  output logic [3:0] wr_idx,
  output logic [15:0] wr_data,
  input wire agu_pkg::agu_rsp_t rsp
);
  import agu_pkg::*;
  initial begin
    req = '0;
    wr_en = 1'b0;
    wr_idx = 4'h0;
    wr_data = 16'h0000;
  end
  task automatic load(input logic [3:0] idx, input logic [15:0] val);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    wr_idx <= idx;
    wr_data <= val;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : load
  // Callers may send MAC pointers outside registers 8-11 to check rejection
  // Circular select never names 14; 15 is written to switch circular addressing off
  task automatic issue(input mode_t m, input logic [3:0] p, input logic [3:0] o, input logic [15:0] l,
                       input lit_kind_t k, input logic [12:0] f, input logic pg, output agu_rsp_t r);
    agu_req_t q;
    q = '{1'b1, m, pg, p, o, l, k, f};
    @(posedge clk_sys);
    req <= q;
    @(posedge clk_sys);
    // Idle fields inverted so a stale request cannot pass
    req <= agu_req_t'({1'b0, ~q[$bits(agu_req_t)-2:0]});
    @(negedge clk_sys);
    r = rsp;
  endtask : issue
endmodule : pipe_model
`default_nettype wire
